//--- shared/nvmpc_cfg.svh
// Offsets, field positions, reset values and constants of the NVM control.
`ifndef NVMPC_CFG_SVH
`define NVMPC_CFG_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define NVMPC_IDX_KEY       16'h4008
`define NVMPC_IDX_SCRATCH   16'h4009
`define NVMPC_IDX_CTL       16'h400a
`define NVMPC_IDX_STATUS    16'h4010

// ****************************************************************
// Control word fields
// ****************************************************************
`define NVMPC_CTL_PROG      15
`define NVMPC_CTL_MEM       13
`define NVMPC_CTL_FINAL     11
`define NVMPC_CTL_VERIFY    10
`define NVMPC_CTL_WRITE     9
`define NVMPC_CTL_READ      8
`define NVMPC_CTL_MARGIN_HI 7
`define NVMPC_CTL_MARGIN_LO 6
`define NVMPC_CTL_BULK      5
`define NVMPC_CTL_PAGE_HI   1
`define NVMPC_CTL_PAGE_LO   0

// ****************************************************************
// Status word fields
// ****************************************************************
`define NVMPC_ST_PROG       0
`define NVMPC_ST_FINAL      1
`define NVMPC_ST_UNLOCK     2
`define NVMPC_ST_REJECT     3

// ****************************************************************
// Command slots
// ****************************************************************
`define NVMPC_CMD_READ      0
`define NVMPC_CMD_WRITE     1
`define NVMPC_CMD_VERIFY    2
`define NVMPC_CMD_FINAL     3
`define NVMPC_NUM_CMD       4

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define NVMPC_SCRATCH_RST   16'h0000
`define NVMPC_MEM_RST       1'b1
`define NVMPC_MARGIN_RST    2'h0
`define NVMPC_MARGIN_RSVD   2'h1
`define NVMPC_PAGE_RST      2'h0
`define NVMPC_PAGE_IMG_RSVD 2'h3
`define NVMPC_IMG_PAGE_BASE 3'h2
`define NVMPC_UNLOCK_KEY    16'h9716

`endif

//--- shared/nvmpc_pkg.sv
// Types shared by the NVM program control block.
package nvmpc_pkg;
  typedef logic [2:0] nvmpc_page_t;
  typedef logic [15:0] nvmpc_word_t;
endpackage

//--- hw/nvmpc_cmd_pulse.sv
// One command slot: turns an accepted command bit into a one-cycle pulse.
module nvmpc_cmd_pulse (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Command request
  input  wire logic fire,
  input  wire logic allow,
  // Issued command
  output logic      pulse_q
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= fire && allow;
    end
  end

endmodule // nvmpc_cmd_pulse

//--- hw/nvmpc_top.sv
// NVM program control and host scratch register behind an APB slave.
// Behaviour
// - 16-bit scratch register, read/write, resets zero.
// - Scratch keeps its value through backup state.
// - Program state set by write, held until reset.
// - Bit 13 targets OTP (1) or image.
// - Finalise command blocks later OTP programming.
// - Bit 10 issues verify; zero does nothing.
// - Bit 9 issues write; zero does nothing.
// - Bit 8 issues read; zero does nothing.
// - Margin field: normal, margin 1, margin 2.
// - Bit 5 chooses single page or all.
// - OTP single page: codes map to 0..3.
// - Image single page: codes map to 2..4.
// - Protected fields writable only when unlocked.
//
// Local design decision: the APB interface to the registers.
`include "nvmpc_cfg.svh"

module nvmpc_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Power state, from the always-on domain
  input  wire logic        backup_state,
  // Memory command outputs
  output logic             nvm_program_state_select,
  output logic             nvm_target_otp,
  output logic      [1:0]  nvm_margin_level,
  output logic             nvm_all_pages,
  output logic      [2:0]  nvm_page,
  output logic             nvm_cmd_read,
  output logic             nvm_cmd_write,
  output logic             nvm_cmd_verify,
  output logic             nvm_cmd_finalise,
  output logic             nvm_finalised,
  // Scratch value
  output logic      [15:0] host_scratch_value
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic                      acc;
  logic                      wr_en;
  logic                      hit_key;
  logic                      hit_scr;
  logic                      hit_ctl;
  logic                      hit_st;
  logic                      mapped;
  logic                      pready_q;
  logic                      pslverr_q;
  logic [31:0]               prdata_q;
  logic [31:0]               rd_d;
  nvmpc_pkg::nvmpc_word_t    wdat;

  assign wdat    = pwdata[15:0];
  assign acc     = psel && penable;
  assign hit_key = (paddr[17:2] == `NVMPC_IDX_KEY);
  assign hit_scr = (paddr[17:2] == `NVMPC_IDX_SCRATCH);
  assign hit_ctl = (paddr[17:2] == `NVMPC_IDX_CTL);
  assign hit_st  = (paddr[17:2] == `NVMPC_IDX_STATUS);
  assign mapped  = (hit_key || hit_scr || hit_ctl || hit_st)
                   && (paddr[1:0] == 2'h0);
  // Writes land only on the completing edge of a mapped access.
  assign wr_en   = acc && pready_q && pwrite && mapped;

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [15:0]               scratch_q;
  logic                      unlocked_q;
  logic                      prog_q;
  logic                      mem_q;
  logic [1:0]                margin_q;
  logic                      bulk_q;
  logic [1:0]                page_q;
  logic                      final_q;
  logic                      reject_q;
  logic                      mem_d;
  logic [1:0]                margin_d;
  logic                      bulk_d;
  logic [1:0]                page_d;
  nvmpc_pkg::nvmpc_page_t    phys_d;
  nvmpc_pkg::nvmpc_page_t    phys_q;
  logic                      ctl_wr;
  logic                      ctl_wr_key;
  logic [`NVMPC_NUM_CMD-1:0] cmd_fire;
  logic [`NVMPC_NUM_CMD-1:0] cmd_allow;
  logic [`NVMPC_NUM_CMD-1:0] cmd_q;
  logic                      page_ok;
  logic                      margin_ok;
  logic                      any_reject;

  // ****************************************************************
  // Backup state synchroniser
  // ****************************************************************
  logic bk_s1_q;
  logic bk_s2_q;
  logic bk_s3_q;
  logic bk_q;
  logic bk_entry;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bk_s1_q <= 1'b0;
      bk_s2_q <= 1'b0;
      bk_s3_q <= 1'b0;
      bk_q    <= 1'b0;
    end else begin
      bk_s1_q <= backup_state;
      bk_s2_q <= bk_s1_q;
      bk_s3_q <= bk_s2_q;
      if (bk_s2_q == bk_s3_q) begin
        bk_q <= bk_s3_q;
      end
    end
  end

  assign bk_entry = (bk_s2_q == bk_s3_q) && bk_s3_q && !bk_q;

  // ****************************************************************
  // Scratch register
  // ****************************************************************
  // Only device reset clears it; the backup state has no path here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scratch_q <= `NVMPC_SCRATCH_RST;
    end else if (wr_en && hit_scr) begin
      scratch_q <= wdat;
    end
  end

  // ****************************************************************
  // Unlock key
  // ****************************************************************
  // Entering backup drops the unlock so stale access cannot survive it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlocked_q <= 1'b0;
    end else if (bk_entry) begin
      unlocked_q <= 1'b0;
    end else if (wr_en && hit_key) begin
      unlocked_q <= (wdat == `NVMPC_UNLOCK_KEY);
    end
  end

  // ****************************************************************
  // Control fields
  // ****************************************************************
  assign ctl_wr     = wr_en && hit_ctl;
  assign ctl_wr_key = ctl_wr && unlocked_q;

  always_comb begin
    mem_d    = mem_q;
    margin_d = margin_q;
    bulk_d   = bulk_q;
    page_d   = page_q;
    if (ctl_wr) begin
      bulk_d = wdat[`NVMPC_CTL_BULK];
      page_d = wdat[`NVMPC_CTL_PAGE_HI:`NVMPC_CTL_PAGE_LO];
    end
    if (ctl_wr_key) begin
      mem_d    = wdat[`NVMPC_CTL_MEM];
      margin_d = wdat[`NVMPC_CTL_MARGIN_HI:`NVMPC_CTL_MARGIN_LO];
    end
  end

  always_comb begin
    if (mem_d) begin
      phys_d = {1'b0, page_d};
    end else begin
      phys_d = `NVMPC_IMG_PAGE_BASE + {1'b0, page_d};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_q    <= `NVMPC_MEM_RST;
      margin_q <= `NVMPC_MARGIN_RST;
      bulk_q   <= 1'b0;
      page_q   <= `NVMPC_PAGE_RST;
      phys_q   <= {1'b0, `NVMPC_PAGE_RST};
    end else begin
      mem_q    <= mem_d;
      margin_q <= margin_d;
      bulk_q   <= bulk_d;
      page_q   <= page_d;
      phys_q   <= phys_d;
    end
  end

  // Program state can only be entered; nothing but reset leaves it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_q <= 1'b0;
    end else if (ctl_wr_key && wdat[`NVMPC_CTL_PROG]) begin
      prog_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Commands
  // ****************************************************************
  // Reserved margin refuses read and verify; the reserved image page code refuses read, write and verify.
  assign margin_ok = (margin_d != `NVMPC_MARGIN_RSVD);
  assign page_ok   = bulk_d || mem_d
                     || (page_d != `NVMPC_PAGE_IMG_RSVD);

  assign cmd_fire[`NVMPC_CMD_READ]   = ctl_wr_key && wdat[`NVMPC_CTL_READ];
  assign cmd_fire[`NVMPC_CMD_WRITE]  = ctl_wr_key && wdat[`NVMPC_CTL_WRITE];
  assign cmd_fire[`NVMPC_CMD_VERIFY] = ctl_wr_key
                                       && wdat[`NVMPC_CTL_VERIFY];
  assign cmd_fire[`NVMPC_CMD_FINAL]  = ctl_wr_key && wdat[`NVMPC_CTL_FINAL];

  assign cmd_allow[`NVMPC_CMD_READ]   = margin_ok && page_ok;
  assign cmd_allow[`NVMPC_CMD_WRITE]  = page_ok
                                        && !(mem_d && final_q);
  assign cmd_allow[`NVMPC_CMD_VERIFY] = margin_ok && page_ok;
  assign cmd_allow[`NVMPC_CMD_FINAL]  = 1'b1;

  for (genvar i = 0; i < `NVMPC_NUM_CMD; i++) begin : g_cmd
    nvmpc_cmd_pulse u_pulse (
      .pclk    (pclk),
      .presetn (presetn),
      .fire    (cmd_fire[i]),
      .allow   (cmd_allow[i]),
      .pulse_q (cmd_q[i])
    );
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      final_q <= 1'b0;
    end else if (cmd_fire[`NVMPC_CMD_FINAL]) begin
      final_q <= 1'b1;
    end
  end

  // A refusal in the same cycle as the clear wins over the clear.
  assign any_reject = |(cmd_fire & ~cmd_allow);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reject_q <= 1'b0;
    end else if (any_reject) begin
      reject_q <= 1'b1;
    end else if (wr_en && hit_st && pwdata[`NVMPC_ST_REJECT]) begin
      reject_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Read path and answer
  // ****************************************************************
  always_comb begin
    rd_d = 32'h0000_0000;
    if (hit_scr) begin
      rd_d[15:0] = scratch_q;
    end else if (hit_ctl) begin
      rd_d[`NVMPC_CTL_PROG]   = prog_q;
      rd_d[`NVMPC_CTL_MEM]    = mem_q;
      rd_d[`NVMPC_CTL_MARGIN_HI:`NVMPC_CTL_MARGIN_LO] = margin_q;
      rd_d[`NVMPC_CTL_BULK]   = bulk_q;
      rd_d[`NVMPC_CTL_PAGE_HI:`NVMPC_CTL_PAGE_LO] = page_q;
    end else if (hit_st) begin
      rd_d[`NVMPC_ST_PROG]    = prog_q;
      rd_d[`NVMPC_ST_FINAL]   = final_q;
      rd_d[`NVMPC_ST_UNLOCK]  = unlocked_q;
      rd_d[`NVMPC_ST_REJECT]  = reject_q;
    end
  end

  // One wait state: pready rises the cycle after the access phase opens.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= acc && !pready_q;
      pslverr_q <= acc && !pready_q && !mapped;
      prdata_q  <= (acc && !pready_q && !pwrite && mapped)
                   ? rd_d : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata                   = prdata_q;
  assign pready                   = pready_q;
  assign pslverr                  = pslverr_q;
  assign host_scratch_value       = scratch_q;
  assign nvm_program_state_select = prog_q;
  assign nvm_target_otp           = mem_q;
  assign nvm_margin_level         = margin_q;
  assign nvm_all_pages            = bulk_q;
  assign nvm_page                 = phys_q;
  assign nvm_cmd_read             = cmd_q[`NVMPC_CMD_READ];
  assign nvm_cmd_write            = cmd_q[`NVMPC_CMD_WRITE];
  assign nvm_cmd_verify           = cmd_q[`NVMPC_CMD_VERIFY];
  assign nvm_cmd_finalise         = cmd_q[`NVMPC_CMD_FINAL];
  assign nvm_finalised            = final_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_ctl_unlocked_bit(int b);
    ctl_wr && unlocked_q && wdat[b];
  endsequence

  property p_scratch_hold;
    @(posedge pclk) disable iff (!presetn)
      !(wr_en && hit_scr) |=> $stable(scratch_q);
  endproperty
  a_scratch_hold: assert property (p_scratch_hold)
    else $error("scratch changed without a write");

  property p_scratch_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_scr) |=> host_scratch_value == $past(wdat);
  endproperty
  a_scratch_write: assert property (p_scratch_write)
    else $error("scratch write not stored");

  property p_prog_enter;
    @(posedge pclk) disable iff (!presetn)
      s_ctl_unlocked_bit(`NVMPC_CTL_PROG) |=> prog_q [*3];
  endproperty
  a_prog_enter: assert property (p_prog_enter)
    else $error("program state not entered or not held");

  property p_locked_ignore;
    @(posedge pclk) disable iff (!presetn)
      (ctl_wr && !unlocked_q) |=> $stable(mem_q) && $stable(margin_q)
                                  && $stable(prog_q) && !(|cmd_q);
  endproperty
  a_locked_ignore: assert property (p_locked_ignore)
    else $error("locked write changed a protected field");

  property p_bulk_free;
    @(posedge pclk) disable iff (!presetn)
      ctl_wr |=> nvm_all_pages == $past(wdat[`NVMPC_CTL_BULK]);
  endproperty
  a_bulk_free: assert property (p_bulk_free)
    else $error("page-count field not written");

  property p_read_issue;
    @(posedge pclk) disable iff (!presetn)
      (s_ctl_unlocked_bit(`NVMPC_CTL_READ) ##0 (margin_ok && page_ok))
        |=> nvm_cmd_read ##1 !nvm_cmd_read;
  endproperty
  a_read_issue: assert property (p_read_issue)
    else $error("read command not a single pulse");

  property p_final_blocks;
    @(posedge pclk) disable iff (!presetn)
      nvm_cmd_write |-> !(nvm_target_otp && $past(nvm_finalised));
  endproperty
  a_final_blocks: assert property (p_final_blocks)
    else $error("OTP write issued after finalise");

  property p_margin_rsvd;
    @(posedge pclk) disable iff (!presetn)
      (nvm_cmd_read || nvm_cmd_verify)
        |-> nvm_margin_level != `NVMPC_MARGIN_RSVD;
  endproperty
  a_margin_rsvd: assert property (p_margin_rsvd)
    else $error("command issued at reserved margin");

  property p_page_map;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |-> nvm_page == (mem_q ? {1'b0, page_q}
                                  : 3'h2 + {1'b0, page_q});
  endproperty
  a_page_map: assert property (p_page_map)
    else $error("page mapping wrong");

  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn)
      (acc && !pready) |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("APB answer not after one wait state");

endmodule // nvmpc_top

//--- verification/nvmpc_top_bench.sv
// Self-checking bench for the NVM program control and scratch register.
`include "nvmpc_cfg.svh"

module nvmpc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Design connections
  // ****************************************************************
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [17:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        backup_state;
  logic        prog_sel;
  logic        tgt_otp;
  logic [1:0]  margin;
  logic        all_pages;
  logic [2:0]  page;
  logic [3:0]  cmd;
  logic        finalised;
  logic [15:0] scratch;

  int          n_fail    = 0;
  int          cmp_count = 0;
  integer      seed      = 32'h655e9e5b;
  int          m_unl, m_prog, m_mem, m_mrg, m_bulk, m_page, m_fin, m_scr;

  nvmpc_top u_dut (
    .pclk                     (pclk),
    .presetn                  (presetn),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .backup_state             (backup_state),
    .nvm_program_state_select (prog_sel),
    .nvm_target_otp           (tgt_otp),
    .nvm_margin_level         (margin),
    .nvm_all_pages            (all_pages),
    .nvm_page                 (page),
    .nvm_cmd_read             (cmd[0]),
    .nvm_cmd_write            (cmd[1]),
    .nvm_cmd_verify           (cmd[2]),
    .nvm_cmd_finalise         (cmd[3]),
    .nvm_finalised            (finalised),
    .host_scratch_value       (scratch)
  );

  always #2.5 pclk = ~pclk;

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  function automatic logic [17:0] a(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction

  function automatic logic [31:0] ctl_word();
    return m_prog * 32768 + m_mem * 8192 + m_mrg * 64 + m_bulk * 32
           + m_page;
  endfunction

  // Entered just after a clock edge; returns at the edge that took pready.
  task automatic apb(input logic wr, input logic [17:0] ad,
                     input logic [31:0] wd, input logic exp_err,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    chk("pready", 32'h1, {31'h0, pready});
    chk("pslverr", {31'h0, exp_err}, {31'h0, pslverr});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    apb(1'b0, a(idx), 32'h0, 1'b0, rd);
    chk("read", exp, rd);
  endtask

  task automatic wr_scr(input logic [15:0] d);
    logic [31:0] rd;
    apb(1'b1, a(`NVMPC_IDX_SCRATCH), {16'h0, d}, 1'b0, rd);
    m_scr = d;
    rd_chk(`NVMPC_IDX_SCRATCH, m_scr);
    chk("scratch", m_scr, {16'h0, scratch});
  endtask

  task automatic key(input logic [15:0] d);
    logic [31:0] rd;
    apb(1'b1, a(`NVMPC_IDX_KEY), {16'h0, d}, 1'b0, rd);
    m_unl = (d == `NVMPC_UNLOCK_KEY);
  endtask

  task automatic wr_ctl(input logic [15:0] d);
    logic [31:0] rd;
    logic [3:0]  ec;
    int          rsv;
    apb(1'b1, a(`NVMPC_IDX_CTL), {16'h0, d}, 1'b0, rd);
    if (m_unl) begin
      m_prog = m_prog | d[15];
      m_mem  = d[13];
      m_mrg  = d[7:6];
    end
    m_bulk = d[5];
    m_page = d[1:0];
    rsv   = !m_mem && !m_bulk && m_page == 3;
    ec[0] = m_unl && d[8] && m_mrg != 1 && !rsv;
    ec[1] = m_unl && d[9] && !rsv && !(m_mem && m_fin);
    ec[2] = m_unl && d[10] && m_mrg != 1 && !rsv;
    ec[3] = m_unl && d[11];
    @(posedge pclk);
    chk("cmd", {28'h0, ec}, {28'h0, cmd});
    chk("fields", m_prog * 32 + m_mem * 16 + m_mrg * 4 + m_bulk * 2,
        {26'h0, prog_sel, tgt_otp, margin, all_pages, 1'b0});
    if (!rsv)
      chk("page", m_mem ? m_page : m_page + 2, {29'h0, page});
    m_fin = m_fin | ec[3];
    @(posedge pclk);
    chk("cmd_off", 32'h0, {28'h0, cmd});
    chk("finalised", m_fin, {31'h0, finalised});
  endtask

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    {m_unl, m_prog, m_mrg, m_bulk, m_page, m_fin, m_scr} = '0;
    m_mem = 1;
    chk("rst_out", 32'h8, {27'h0, prog_sel, tgt_otp, finalised, cmd[0],
        all_pages});
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin : main
    logic [31:0] v;
    logic [15:0] tbl [6];
    tbl = '{16'h2100, 16'h2540, 16'h0503, 16'h2700, 16'h20c2, 16'h0463};
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    backup_state = 1'b0;
    do_reset();
    rd_chk(`NVMPC_IDX_SCRATCH, 32'h0);
    rd_chk(`NVMPC_IDX_CTL, 32'h2000);
    for (int i = 0; i < 4; i++) wr_scr($random(seed));
    wr_ctl(16'haf63);
    rd_chk(`NVMPC_IDX_CTL, ctl_word());
    key(16'h9716);
    foreach (tbl[i]) wr_ctl(tbl[i]);
    for (int i = 0; i < 40; i++) begin
      v = $random(seed);
      wr_ctl(v[15:0] & 16'h27e3);
    end
    rd_chk(`NVMPC_IDX_CTL, ctl_word());
    wr_ctl(16'h8000);
    wr_ctl(16'h2000);
    wr_ctl(16'h2800);
    wr_ctl(16'h2200);
    wr_ctl(16'h0200);
    rd_chk(`NVMPC_IDX_STATUS, 32'hf);
    key(16'h1234);
    wr_ctl(16'h0100);
    // Backup entry goes through a synchroniser, so allow settling time.
    key(16'h9716);
    wr_scr(16'ha5c3);
    backup_state <= 1'b1;
    repeat (8) @(posedge pclk);
    backup_state <= 1'b0;
    m_unl = 0;
    repeat (6) @(posedge pclk);
    chk("scratch", m_scr, {16'h0, scratch});
    rd_chk(`NVMPC_IDX_SCRATCH, m_scr);
    wr_ctl(16'h2100);
    apb(1'b0, a(16'h4011), 32'h0, 1'b1, v);
    chk("prdata_err", 32'h0, v);
    apb(1'b1, a(`NVMPC_IDX_SCRATCH) | 18'h2, 32'h1234, 1'b1, v);
    rd_chk(`NVMPC_IDX_SCRATCH, m_scr);
    do_reset();
    rd_chk(`NVMPC_IDX_SCRATCH, 32'h0);
    rd_chk(`NVMPC_IDX_CTL, 32'h2000);
    finish_test();
  end

  initial begin : watchdog
    repeat (20000) @(posedge pclk);
    n_fail++;
    $display("BAD watchdog expected done seen hang");
    finish_test();
  end
endmodule // nvmpc_top_bench
